// ==== hw/hwc_defs.svh ====
/*
 * Constants for the halt-mode wake-up controller: register indices,
 * field positions, reset values and timing counts.
 * Assumes inclusion by bare name from every file that needs them.
 */
`ifndef HWC_DEFS_SVH
`define HWC_DEFS_SVH

// ************************************************************
// Register indices (byte address is four times the index)
// ************************************************************
`define HWC_IDX_AWU_CSR 8'h2b
`define HWC_IDX_AWU_PRE 8'h2c
`define HWC_IDX_CTRL 8'h2d
`define HWC_IDX_STATUS 8'h2e

// ************************************************************
// Field positions
// ************************************************************
`define HWC_CSR_EN_BIT 0
`define HWC_CSR_MEAS_BIT 1
`define HWC_CSR_FLAG_BIT 2
`define HWC_CTRL_RTC_IE_BIT 0
`define HWC_CTRL_WDG_EN_BIT 1
`define HWC_CTRL_WDG_OPT_BIT 2
`define HWC_CTRL_LONG_BIT 3

// ************************************************************
// Reset values, encodings and timing counts
// ************************************************************
`define HWC_PRE_RESET 8'hff
`define HWC_PRE_FORBIDDEN 8'h00
`define HWC_OPC_HALT 8'h8e
`define HWC_MASK_HALT 2'h2
`define HWC_STAB_SHORT 13'h0100
`define HWC_STAB_LONG 13'h1000
`define HWC_FIXED_DIV 7'h40

`endif

// ==== hw/hwc_pkg.sv ====
/*
 * Types shared by the halt-mode wake-up controller and its timer.
 * Assumes hwc_defs.svh is available on the include path.
 */
`default_nettype none

package hwc_pkg;

    typedef enum logic [2:0] {
        HWC_RUN = 3'b000,
        HWC_HALT = 3'b001,
        HWC_ACTIVE = 3'b010,
        HWC_AWU_HALT = 3'b011,
        HWC_STAB = 3'b100
    } hwc_mode_t;

    typedef struct packed {
        logic [5:0] fixedCnt;
        logic [7:0] preCnt;
        logic expire;
    } hwc_tmr_state_t;

endpackage : hwc_pkg

`default_nettype wire

// ==== hw/hwc_awu_if.sv ====
/*
 * Carrier between the controller and the auto-wake timer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface hwc_awu_if;
    logic run;
    logic [7:0] prescale;
    logic rcTick;
    logic expire;
    modport timer (input run, input prescale, input rcTick, output expire);
    modport ctrl (output run, output prescale, output rcTick, input expire);
endinterface : hwc_awu_if

`default_nettype wire

// ==== hw/hwc_awu_timer.sv ====
/*
 * Auto-wake delay timer: fixed divide by 64, then the programmable prescaler.
 * Assumes rcTick is a synchronised one-cycle pulse per rising RC oscillator edge.
 */
`timescale 1ns/1ps
`default_nettype none
`include "hwc_defs.svh"

module hwc_awu_timer
    import hwc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Controller side
    hwc_awu_if.timer awu
);

    hwc_tmr_state_t st;
    hwc_tmr_state_t next_st;

    // ************************************************************
    // Divider chain
    // ************************************************************
    always_comb begin
        next_st = st;
        next_st.expire = 1'b0;
        if (!awu.run) begin
            next_st.fixedCnt = 6'h00;
            next_st.preCnt = 8'h00;
        end else if (awu.rcTick) begin
            next_st.fixedCnt = st.fixedCnt + 6'h01;
            if (st.fixedCnt == 6'(`HWC_FIXED_DIV - 7'h01)) begin
                // Delay is prescale times 64 RC periods
                if (st.preCnt + 8'h01 >= awu.prescale) begin
                    next_st.preCnt = 8'h00;
                    next_st.expire = 1'b1;
                end else begin
                    next_st.preCnt = st.preCnt + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign awu.expire = st.expire;

endmodule : hwc_awu_timer

`default_nettype wire

// ==== hw/hwc_halt_ctrl.sv ====
/*
 * Halt, active-halt and auto-wake-halt controller with its Avalon-MM registers.
 * Assumes the CPU core presents each fetched opcode with a valid strobe, and
 * that wake interrupts come from logic on ref_clk; the reset and RC inputs are pins.
 */
// Our own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "hwc_defs.svh"

module hwc_halt_ctrl
    import hwc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [9:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // CPU core
    input wire logic opValid,
    input wire logic [7:0] opcode,
    input wire logic wakeIrq,
    input wire logic rtcIrq,
    output logic maskForce,
    output logic [1:0] maskValue,
    output logic serviceIrq,
    output logic fetchVector,
    // Pins
    input wire logic resetPin,
    input wire logic rcClkPin,
    // Clock gating, watchdog and timer
    output logic mainOscEn,
    output logic periphClkEn,
    output logic rtcClkEn,
    output logic wdgReset,
    output logic awuIrq,
    output logic captureOne
);

    typedef struct packed {
        hwc_mode_t mode;
        logic waitReq;
        logic [31:0] rdata;
        logic auto_wake_enable;
        logic awuMeas;
        logic awuFlag;
        logic [7:0] pre;
        logic rtcIrqEn;
        logic wdgEn;
        logic wdgHaltOpt;
        logic longStab;
        logic [12:0] stabCnt;
        logic wakeByReset;
        logic oscEn;
        logic periphEn;
        logic rtcEn;
        logic maskForce;
        logic serviceIrq;
        logic fetchVector;
        logic wdgReset;
        logic capture;
        logic rstS1;
        logic rstS2;
        logic rcS1;
        logic rcS2;
        logic rcPrev;
    } hwc_state_t;

    hwc_state_t st;
    hwc_state_t next_st;
    hwc_awu_if awuBus ();

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic isReg(input logic [9:0] addr, input logic [7:0] idx);
        isReg = (addr == {idx, 2'b00});
    endfunction : isReg

    function automatic logic [12:0] stabLoad(input logic longSel);
        stabLoad = longSel ? (`HWC_STAB_LONG - 13'h0001) : (`HWC_STAB_SHORT - 13'h0001);
    endfunction : stabLoad

    logic haltOp;
    logic busRd;
    logic busWr;
    logic rcTick;

    assign haltOp = opValid && (opcode == `HWC_OPC_HALT);
    assign busRd = read && !st.waitReq;
    assign busWr = write && !st.waitReq && byteenable[0];
    // Edge detector reads only the second synchroniser stage
    assign rcTick = st.rcS2 && !st.rcPrev;

    assign awuBus.run = (st.mode == HWC_AWU_HALT);
    assign awuBus.prescale = st.pre;
    assign awuBus.rcTick = rcTick;

    // ************************************************************
    // Auto-wake timer
    // ************************************************************
    hwc_awu_timer u_timer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .awu(awuBus.timer)
    );

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        next_st = st;
        next_st.rstS1 = resetPin;
        next_st.rstS2 = st.rstS1;
        next_st.rcS1 = rcClkPin;
        next_st.rcS2 = st.rcS1;
        next_st.rcPrev = st.rcS2;
        next_st.serviceIrq = 1'b0;
        next_st.fetchVector = 1'b0;
        next_st.wdgReset = 1'b0;

        // Bus handshake: one wait cycle, then the answer
        next_st.waitReq = !((read || write) && st.waitReq);
        if ((read || write) && st.waitReq) begin
            next_st.rdata = 32'h0000_0000;
            if (read) begin
                if (isReg(address, `HWC_IDX_AWU_CSR)) begin
                    next_st.rdata[`HWC_CSR_EN_BIT] = st.auto_wake_enable;
                    next_st.rdata[`HWC_CSR_MEAS_BIT] = st.awuMeas;
                    next_st.rdata[`HWC_CSR_FLAG_BIT] = st.awuFlag;
                end else if (isReg(address, `HWC_IDX_AWU_PRE)) begin
                    next_st.rdata[7:0] = st.pre;
                end else if (isReg(address, `HWC_IDX_CTRL)) begin
                    next_st.rdata[`HWC_CTRL_RTC_IE_BIT] = st.rtcIrqEn;
                    next_st.rdata[`HWC_CTRL_WDG_EN_BIT] = st.wdgEn;
                    next_st.rdata[`HWC_CTRL_WDG_OPT_BIT] = st.wdgHaltOpt;
                    next_st.rdata[`HWC_CTRL_LONG_BIT] = st.longStab;
                end else if (isReg(address, `HWC_IDX_STATUS)) begin
                    next_st.rdata[2:0] = st.mode;
                end
            end
        end

        // Flag clears on the read that completes; a same-cycle set still wins
        if (busRd && isReg(address, `HWC_IDX_AWU_CSR)) begin
            next_st.awuFlag = 1'b0;
        end
        if (busWr) begin
            if (isReg(address, `HWC_IDX_AWU_CSR)) begin
                next_st.auto_wake_enable = writedata[`HWC_CSR_EN_BIT];
                next_st.awuMeas = writedata[`HWC_CSR_MEAS_BIT];
            end else if (isReg(address, `HWC_IDX_AWU_PRE)) begin
                if (writedata[7:0] != `HWC_PRE_FORBIDDEN) begin
                    next_st.pre = writedata[7:0];
                end
            end else if (isReg(address, `HWC_IDX_CTRL)) begin
                next_st.rtcIrqEn = writedata[`HWC_CTRL_RTC_IE_BIT];
                next_st.wdgEn = writedata[`HWC_CTRL_WDG_EN_BIT];
                next_st.wdgHaltOpt = writedata[`HWC_CTRL_WDG_OPT_BIT];
                next_st.longStab = writedata[`HWC_CTRL_LONG_BIT];
            end
        end

        if (awuBus.expire) begin
            next_st.awuFlag = 1'b1;
        end

        unique case (st.mode)
            HWC_RUN: begin
                if (haltOp) begin
                    if (st.rtcIrqEn) begin
                        // Active halt takes priority and never trips the watchdog
                        next_st.mode = HWC_ACTIVE;
                        next_st.maskForce = 1'b1;
                        next_st.periphEn = 1'b0;
                        next_st.rtcEn = 1'b1;
                    end else if (st.wdgEn && !st.wdgHaltOpt) begin
                        next_st.wdgReset = 1'b1;
                    end else begin
                        next_st.mode = st.auto_wake_enable ? HWC_AWU_HALT : HWC_HALT;
                        next_st.maskForce = 1'b1;
                        next_st.oscEn = 1'b0;
                        next_st.periphEn = 1'b0;
                        next_st.rtcEn = 1'b0;
                    end
                end
            end
            HWC_HALT, HWC_AWU_HALT: begin
                // A pending interrupt wakes on the first halted cycle
                if (st.rstS2 || wakeIrq || awuBus.expire) begin
                    next_st.mode = HWC_STAB;
                    next_st.oscEn = 1'b1;
                    next_st.wakeByReset = st.rstS2;
                    next_st.stabCnt = stabLoad(st.longStab);
                end
            end
            HWC_ACTIVE: begin
                if (st.rstS2) begin
                    next_st.mode = HWC_STAB;
                    next_st.wakeByReset = 1'b1;
                    next_st.stabCnt = stabLoad(st.longStab);
                end else if (wakeIrq || rtcIrq) begin
                    // Oscillator never stopped, so no stabilisation here
                    next_st.mode = HWC_RUN;
                    next_st.periphEn = 1'b1;
                    next_st.rtcEn = 1'b0;
                    next_st.serviceIrq = 1'b1;
                    next_st.maskForce = 1'b0;
                end
            end
            HWC_STAB: begin
                if (st.stabCnt == 13'h0000) begin
                    next_st.mode = HWC_RUN;
                    next_st.periphEn = 1'b1;
                    next_st.rtcEn = 1'b0;
                    next_st.maskForce = 1'b0;
                    next_st.serviceIrq = !st.wakeByReset;
                    next_st.fetchVector = st.wakeByReset;
                    next_st.wakeByReset = 1'b0;
                end else begin
                    next_st.stabCnt = st.stabCnt - 13'h0001;
                end
            end
            default: begin
                next_st.mode = HWC_RUN;
            end
        endcase

        // Uses the next mode so capture never stands in the first halted cycle
        next_st.capture = st.awuMeas && (next_st.mode == HWC_RUN) && st.rcS2;
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.mode <= HWC_RUN;
            st.waitReq <= 1'b1;
            st.pre <= `HWC_PRE_RESET;
            st.oscEn <= 1'b1;
            st.periphEn <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign readdata = st.rdata;
    assign waitrequest = st.waitReq;
    assign maskForce = st.maskForce;
    assign maskValue = `HWC_MASK_HALT;
    assign serviceIrq = st.serviceIrq;
    assign fetchVector = st.fetchVector;
    assign mainOscEn = st.oscEn;
    assign periphClkEn = st.periphEn;
    assign rtcClkEn = st.rtcEn;
    assign wdgReset = st.wdgReset;
    assign awuIrq = st.awuFlag;
    assign captureOne = st.capture;

endmodule : hwc_halt_ctrl

`default_nettype wire

// ==== sim/hwc_halt_ctrl_asserts.sv ====
/* Assertions on the halt controller ports.
   Assumes a bind to hwc_halt_ctrl on one clock. */
`timescale 1ns/1ps
`default_nettype none
module hwc_halt_ctrl_asserts (
    // Watched ports
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [9:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic waitrequest,
    input wire logic opValid,
    input wire logic [7:0] opcode,
    input wire logic wakeIrq,
    input wire logic maskForce,
    input wire logic [1:0] maskValue,
    input wire logic serviceIrq,
    input wire logic fetchVector,
    input wire logic mainOscEn,
    input wire logic periphClkEn,
    input wire logic rtcClkEn,
    input wire logic wdgReset,
    input wire logic awuIrq,
    input wire logic captureOne
);
    // ****************
    // Properties
    // ****************
    logic [12:0] stabCnt;
    // Counts cycles with oscillator up but peripherals still gated
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) stabCnt <= 13'h0000;
        else if (mainOscEn && !periphClkEn && !rtcClkEn) stabCnt <= stabCnt + 13'h0001;
        else stabCnt <= 13'h0000;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_halt_taken;
        opValid && opcode == 8'h8e && periphClkEn && !maskForce |=> maskForce ^ wdgReset;
    endproperty
    a_halt_taken: assert property (p_halt_taken) else $error("halt opcode ignored");
    property p_mask;
        maskForce |-> maskValue == 2'h2 && !periphClkEn;
    endproperty
    a_mask: assert property (p_mask) else $error("mask level wrong");
    property p_osc_off;
        !mainOscEn |-> !periphClkEn && !rtcClkEn && maskForce;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("clocks on in halt");
    property p_active;
        rtcClkEn |-> mainOscEn && !periphClkEn && maskForce;
    endproperty
    a_active: assert property (p_active) else $error("active halt clocks wrong");
    property p_wake_irq;
        !mainOscEn && wakeIrq |=> mainOscEn;
    endproperty
    a_wake_irq: assert property (p_wake_irq) else $error("oscillator not restarted");
    property p_stab_len;
        $rose(periphClkEn) && stabCnt != 13'h0000 |-> stabCnt == 13'h0100 || stabCnt == 13'h1000;
    endproperty
    a_stab_len: assert property (p_stab_len) else $error("stabilisation length wrong");
    property p_service;
        serviceIrq || fetchVector |-> periphClkEn && !maskForce ##1 !serviceIrq && !fetchVector;
    endproperty
    a_service: assert property (p_service) else $error("service pulse wrong");
    property p_wdg;
        wdgReset |-> periphClkEn && !maskForce && !rtcClkEn;
    endproperty
    a_wdg: assert property (p_wdg) else $error("watchdog reset outside run");
    property p_flag_clear;
        read && !waitrequest && address == 10'h0ac && periphClkEn |=> !awuIrq;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by read");
    property p_capture;
        captureOne |-> periphClkEn && !maskForce;
    endproperty
    a_capture: assert property (p_capture) else $error("capture outside run");
    property p_bus;
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
    endproperty
    a_bus: assert property (p_bus) else $error("bus answer timing wrong");
    c_active: cover property ($rose(rtcClkEn));
    c_wdg: cover property (wdgReset);
    c_awu: cover property ($rose(awuIrq));
    c_vector: cover property (fetchVector);
endmodule : hwc_halt_ctrl_asserts
`default_nettype wire

// ==== sim/hwc_core_model.sv ====
/* Core and interrupt source model facing the controller.
   Assumes bench commands arrive as one-cycle pulses. */
`timescale 1ns/1ps
`default_nettype none
module hwc_core_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Bench commands
    input wire logic execCmd,
    input wire logic [7:0] execOp,
    input wire logic wakeCmd,
    input wire logic rtcCmd,
    // Controller side
    input wire logic serviceIrq,
    output logic opValid,
    output logic [7:0] opcode,
    output logic wakeIrq,
    output logic rtcIrq
);
    // ****************
    // Core behaviour
    // ****************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            opValid <= 1'b0;
            opcode <= 8'h00;
            wakeIrq <= 1'b0;
            rtcIrq <= 1'b0;
        end else begin
            // Bench only halts with a wake source armed
            opValid <= execCmd;
            // Idle opcode keeps changing so a stale byte is never trusted
            opcode <= execCmd ? execOp : ~opcode;
            // Requests stand until serviced, when the core stacks its codes
            wakeIrq <= wakeCmd || (wakeIrq && !serviceIrq);
            rtcIrq <= rtcCmd || (rtcIrq && !serviceIrq);
        end
    end
endmodule : hwc_core_model
`default_nettype wire

// ==== sim/hwc_halt_ctrl_tb_top.sv ====
/* Bench for the halt controller: bus tasks, mode table, wake timing.
   Assumes the core model and the checker in sim/. */
`timescale 1ns/1ps
`default_nettype none
module hwc_halt_ctrl_tb_top;
    // ****************
    // Signals and tasks
    // ****************
    logic ref_clk = 1'b0;
    logic rst_n, read, write, resetPin, rcClkPin, execCmd, wakeCmd, rtcCmd, seen;
    logic [9:0] address;
    logic [31:0] writedata, readdata, q;
    logic [3:0] byteenable;
    logic [7:0] execOp, opcode, v;
    logic [1:0] maskValue, m;
    logic waitrequest, opValid, wakeIrq, rtcIrq, maskForce, serviceIrq, fetchVector;
    logic mainOscEn, periphClkEn, rtcClkEn, wdgReset, awuIrq, captureOne;
    logic [7:0] ctab [7] = '{8'h00, 8'h01, 8'h01, 8'h03, 8'h02, 8'h06, 8'h08};
    logic [7:0] stab [7] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00};
    int num_errors = 0, total_checks = 0, seed = 90600, n, i, e;
    always #2.5 ref_clk = ~ref_clk;
    // RC pin runs unrelated to ref_clk
    always #21 rcClkPin = ~rcClkPin;
    hwc_halt_ctrl dut (.*);
    hwc_core_model core (.*);
    function automatic logic [1:0] exp_mode(input logic [7:0] c);
        if (c[0]) return 2'h2;
        if (c[1] && !c[2]) return 2'h0;
        return 2'h1;
    endfunction : exp_mode
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge ref_clk);
        read <= ~w;
        write <= w;
        address <= a;
        writedata <= {24'h000000, d};
        do begin
            @(posedge ref_clk);
            k++;
        end while (waitrequest !== 1'b0 && k < 100);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (k >= 100) num_errors++;
    endtask : bus
    task automatic exec(input logic [7:0] op);
        @(posedge ref_clk);
        execOp <= op;
        execCmd <= 1'b1;
        seen = 1'b0;
        repeat (4) begin
            @(posedge ref_clk);
            execCmd <= 1'b0;
            seen = seen | wdgReset;
        end
    endtask : exec
    task automatic wake_wait(output int k);
        k = 0;
        do begin
            @(posedge ref_clk);
            wakeCmd <= 1'b0;
            rtcCmd <= 1'b0;
            resetPin <= 1'b0;
            k++;
        end while (serviceIrq !== 1'b1 && fetchVector !== 1'b1 && k < 5000);
    endtask : wake_wait
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (40000) @(posedge ref_clk);
        num_errors++;
        tally_and_finish;
    end
    // ****************
    // Scenarios
    // ****************
    initial begin
        {rst_n, read, write, resetPin, rcClkPin, execCmd, wakeCmd, rtcCmd} = 8'h00;
        address = 10'h000;
        writedata = 32'h00000000;
        byteenable = 4'hf;
        execOp = 8'h00;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        bus(1, 10'h0ac, 8'h04);
        bus(0, 10'h0ac, 8'h00);
        check("csr", q, 32'h00000000);
        bus(0, 10'h0b0, 8'h00);
        check("pre_rst", q, 32'h000000ff);
        bus(1, 10'h3fc, 8'h5a);
        bus(0, 10'h3fc, 8'h00);
        check("unmapped", q, 32'h00000000);
        for (i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            if (v == 8'h00) v = 8'h01;
            bus(1, 10'h0b0, v);
            bus(1, 10'h0b0, 8'h00);
            byteenable <= 4'h0;
            bus(1, 10'h0b0, ~v);
            byteenable <= 4'hf;
            bus(0, 10'h0b0, 8'h00);
            check("pre", q, {24'h000000, v});
            v = 8'($random(seed));
            if (v == 8'h8e) v = 8'h8f;
            exec(v);
            check("nohalt", {seen, maskForce, periphClkEn}, 32'h1);
        end
        for (i = 0; i < 7; i++) begin
            bus(1, 10'h0b4, ctab[i]);
            bus(0, 10'h0b4, 8'h00);
            check("ctrl", q, {24'h000000, ctab[i]});
            bus(1, 10'h0ac, stab[i]);
            exec(8'h8e);
            m = exp_mode(ctab[i]);
            check("wdg", seen, m == 2'h0);
            check("osc", mainOscEn, m != 2'h1);
            check("rtc", rtcClkEn, m == 2'h2);
            check("mask", {maskForce, maskValue}, m == 2'h0 ? 32'h2 : 32'h6);
            bus(0, 10'h0b8, 8'h00);
            check("status", q, (m == 2'h1 && stab[i][0]) ? 32'h3 : 32'(m));
            if (m == 2'h2) begin
                rtcCmd <= 1'b1;
                wake_wait(n);
                check("fast", n <= 4, 1);
            end else if (m == 2'h1) begin
                wakeCmd <= 1'b1;
                wake_wait(n);
                check("wake", n, ctab[i][3] ? 4099 : 259);
            end
        end
        // Reset exit from active halt first, then from plain halt, ending with control cleared
        for (i = 0; i < 2; i++) begin
            bus(1, 10'h0b4, 8'(1 - i));
            exec(8'h8e);
            resetPin <= 1'b1;
            wake_wait(n);
            check("vector", {fetchVector, n >= 259 && n <= 266}, 32'h3);
        end
        v = 8'($unsigned($random(seed)) % 3 + 1);
        e = 64 * v * 42 / 5;
        bus(1, 10'h0b0, v);
        bus(1, 10'h0ac, 8'h01);
        exec(8'h8e);
        bus(0, 10'h0b8, 8'h00);
        check("awu_mode", q, 32'h3);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (awuIrq !== 1'b1 && n < 3000);
        check("awu_time", n > e - 24 && n < e + 24, 1);
        wake_wait(n);
        check("awu_svc", serviceIrq, 1);
        bus(0, 10'h0ac, 8'h00);
        check("flag", q, 32'h00000005);
        bus(0, 10'h0ac, 8'h00);
        check("flag_clr", {q[7:0], awuIrq}, 32'h2);
        bus(1, 10'h0ac, 8'h02);
        n = 0;
        repeat (40) begin
            @(posedge ref_clk);
            n = n + captureOne;
        end
        check("measure", n > 8 && n < 32, 1);
        bus(1, 10'h0ac, 8'h00);
        repeat (4) @(posedge ref_clk);
        check("meas_off", captureOne, 0);
        tally_and_finish;
    end
endmodule : hwc_halt_ctrl_tb_top
bind hwc_halt_ctrl hwc_halt_ctrl_asserts chk (.*);
`default_nettype wire
